// ==== logic/period_pulse_accumulator.sv ====
// period and pulse accumulator channel with an AXI4-Lite register port
// assumes timebase ticks are one-cycle pulses on ref_clk_i; pin is async
`timescale 1ns/1ps
`default_nettype none
`include "ppa_defines.svh"
module period_pulse_accumulator
    import ppa_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // measured pin and timebases
    input wire logic meas_pin_i,
    input wire logic timebase_first_tick_i,
    input wire logic timebase_second_tick_i,
    // dma handshake
    input wire logic dma_ack_i,
    output logic dma_req_o,
    output logic irq_o,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);

    ppa_state_t q;
    ppa_state_t d;
    logic pin_rise;
    logic pin_fall;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [24:0] add24(input logic [23:0] a,
                                          input logic [23:0] b);
        add24 = {1'b0, a} + {1'b0, b};
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= `PPA_FLAGS_OFF);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                m[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge = m;
    endfunction

    function automatic logic [31:0] rd_word(input ppa_state_t s,
                                            input logic [7:0] a);
        logic [31:0] r;
        r = `PPA_RST_WORD;
        case (a)
            `PPA_CTRL_OFF:
            begin
                r[`PPA_CTRL_PRIO_LSB +: 2] = s.prio;
                r[`PPA_CTRL_TB_BIT] = s.tb_sel;
                r[`PPA_CTRL_MODE_LSB +: 2] = s.mode;
                r[`PPA_CTRL_IRQEN_BIT] = s.irq_en;
            end
            `PPA_TARGET_OFF: r[23:0] = s.target;
            `PPA_INTERVAL_OFF: r[23:0] = s.interval;
            `PPA_RESULT_OFF: r = {s.status, s.result};
            `PPA_RUNNING_OFF: r = {s.acc_ovf, s.acc};
            `PPA_COUNT_OFF: r[23:0] = s.count;
            `PPA_FLAGS_OFF:
            begin
                r[`PPA_FLAG_INT_BIT] = s.int_flag;
                r[`PPA_FLAG_DMA_BIT] = s.dma_flag;
                r[`PPA_FLAG_OVR_BIT] = s.overrun;
                r[`PPA_FLAG_VALID_BIT] = s.valid;
            end
            default: r = `PPA_RST_WORD;
        endcase
        rd_word = r;
    endfunction

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    ppa_pin_sync u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .pin_i(meas_pin_i),
        .level_o(),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic tick;
        logic start_e;
        logic end_e;
        logic done;
        logic [23:0] cur_n;
        logic [24:0] sum;
        logic [23:0] cnt_n;
        logic [23:0] tgt;
        logic [31:0] wv;
        logic [3:0] clr;
        tick = 1'b0;
        start_e = 1'b0;
        end_e = 1'b0;
        done = 1'b0;
        cur_n = 24'h000000;
        sum = 25'h0000000;
        cnt_n = 24'h000000;
        tgt = 24'h000000;
        wv = `PPA_RST_WORD;
        clr = 4'h0;
        d = q;

        // ---------------- axi capture ----------------
        if (s_axi_awvalid_i && q.awready)
        begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && q.wready)
        begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata_i;
            d.wstrb = s_axi_wstrb_i;
        end
        if (s_axi_bready_i && q.bvalid)
        begin
            d.bvalid = 1'b0;
        end

        // ---------------- measurement ----------------
        // timebase select
        tick = q.tb_sel ? timebase_second_tick_i : timebase_first_tick_i;
        // edge and kind from mode bits
        case (q.mode)
            MODE_HIGH:
            begin
                start_e = pin_rise;
                end_e = pin_fall;
            end
            MODE_LOW:
            begin
                start_e = pin_fall;
                end_e = pin_rise;
            end
            MODE_RISE:
            begin
                start_e = pin_rise;
                end_e = pin_rise;
            end
            MODE_FALL:
            begin
                start_e = pin_fall;
                end_e = pin_fall;
            end
            default:
            begin
                start_e = 1'b0;
                end_e = 1'b0;
            end
        endcase
        tgt = (q.target == 24'h000000) ? 24'h000001 : q.target;
        cur_n = q.cur + {23'h000000, tick};
        sum = add24(q.acc, cur_n);
        cnt_n = q.count + 24'h000001;

        if (q.prio != 2'h0)
        begin
            case (q.fn)
                FN_ARMED:
                begin
                    if (start_e)
                    begin
                        d.fn = FN_ACTIVE;
                        d.cur = 24'h000000;
                    end
                end
                FN_ACTIVE:
                begin
                    d.cur = cur_n;
                    if (end_e)
                    begin
                        d.cur = 24'h000000;
                        d.acc = sum[23:0];
                        d.count = cnt_n;
                        if (sum[24])
                        begin
                            d.acc_ovf = q.acc_ovf | `PPA_OVF_FLAG;
                        end
                        // pulse modes wait for the next leading edge
                        if (q.mode == MODE_HIGH || q.mode == MODE_LOW)
                        begin
                            d.fn = FN_ARMED;
                        end
                        if (cnt_n >= tgt)
                        begin
                            done = 1'b1;
                            d.result = sum[23:0];
                            d.status = d.acc_ovf;
                            d.acc_ovf = 8'h00;
                            d.acc = 24'h000000;
                            d.count = 24'h000000;
                            d.valid = 1'b1;
                        end
                    end
                    else if (q.interval != 24'h000000 &&
                             cur_n >= q.interval)
                    begin
                        d.cur = 24'h000000;
                        d.acc = sum[23:0];
                        if (sum[24])
                        begin
                            d.acc_ovf = q.acc_ovf | `PPA_OVF_FLAG;
                        end
                    end
                end
                default:
                begin
                    d.fn = q.fn;
                end
            endcase
        end

        // ---------------- register write ----------------
        if (q.aw_have && q.w_have && !q.bvalid)
        begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = addr_ok(q.awaddr) ? `PPA_RESP_OKAY : `PPA_RESP_SLVERR;
            wv = merge(rd_word(q, q.awaddr), q.wdata, q.wstrb);
            case (q.awaddr)
                `PPA_CTRL_OFF:
                begin
                    d.prio = wv[`PPA_CTRL_PRIO_LSB +: 2];
                    d.tb_sel = wv[`PPA_CTRL_TB_BIT];
                    d.mode = meas_mode_t'(wv[`PPA_CTRL_MODE_LSB +: 2]);
                    d.irq_en = wv[`PPA_CTRL_IRQEN_BIT];
                    if (q.prio != 2'h0 && q.fn == FN_ACTIVE)
                    begin
                        if (d.mode != q.mode)
                        begin
                            d.acc_ovf = d.acc_ovf | `PPA_BAD_MODE;
                        end
                        if (d.tb_sel != q.tb_sel)
                        begin
                            d.acc_ovf = d.acc_ovf | `PPA_BAD_TB;
                        end
                    end
                    if (q.wstrb[`PPA_CTRL_SVC_BIT / 8] &&
                        q.wdata[`PPA_CTRL_SVC_BIT])
                    begin
                        d.fn = FN_ARMED;
                        d.cur = 24'h000000;
                        d.acc = 24'h000000;
                        d.acc_ovf = 8'h00;
                        d.count = 24'h000000;
                        d.valid = 1'b0;
                    end
                end
                `PPA_TARGET_OFF:
                begin
                    // values past the limit are clipped
                    d.target = (wv[23:0] > `PPA_TARGET_MAX) ?
                        `PPA_TARGET_MAX : wv[23:0];
                end
                `PPA_INTERVAL_OFF: d.interval = wv[23:0];
                `PPA_FLAGS_OFF: clr = q.wdata[3:0] & {4{q.wstrb[0]}};
                default: clr = 4'h0;
            endcase
        end

        // ---------------- flags, set wins over clear ----------------
        // overrun on uncleared flag
        d.overrun = (q.overrun && !clr[`PPA_FLAG_OVR_BIT]) ||
                    (done && q.int_flag);
        d.int_flag = (q.int_flag && !clr[`PPA_FLAG_INT_BIT]) || done;
        d.dma_flag = (q.dma_flag && !clr[`PPA_FLAG_DMA_BIT] && !dma_ack_i)
                     || done;
        d.irq = d.int_flag && d.irq_en;

        // ---------------- ready and read ----------------
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;
        if (s_axi_rready_i && q.rvalid)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata = rd_word(q, s_axi_araddr_i);
            d.rresp = addr_ok(s_axi_araddr_i) ?
                `PPA_RESP_OKAY : `PPA_RESP_SLVERR;
        end
        d.arready = !d.rvalid;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all from state flops
    // ----------------------------------------------------------------
    assign s_axi_awready_o = q.awready;
    assign s_axi_wready_o = q.wready;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = q.arready;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rresp_o = q.rresp;
    assign s_axi_rdata_o = q.rdata;
    assign irq_o = q.irq;
    assign dma_req_o = q.dma_flag;

endmodule
`default_nettype wire

// ==== logic/ppa_pin_sync.sv ====
// pin synchroniser with edge detection for the measured input
// assumes pin_i is asynchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module ppa_pin_sync
    import ppa_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // pin
    input wire logic pin_i,
    // edges
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    pin_sync_t q;
    pin_sync_t d;

    // edges compare the second stage with its delayed copy in last, never the first
    always_comb
    begin
        d = q;
        d.sync1 = pin_i;
        d.sync2 = q.sync1;
        d.last = q.sync2;
        d.rise = q.sync2 && !q.last;
        d.fall = !q.sync2 && q.last;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign level_o = q.last;
    assign rise_o = q.rise;
    assign fall_o = q.fall;

endmodule
`default_nettype wire

// ==== shared/ppa_defines.svh ====
// constants for the period and pulse accumulator channel
// assumes a 32-bit AXI4-Lite slave with byte offsets below
`ifndef PPA_DEFINES_SVH
`define PPA_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PPA_CTRL_OFF 8'h00
`define PPA_TARGET_OFF 8'h04
`define PPA_INTERVAL_OFF 8'h08
`define PPA_RESULT_OFF 8'h0C
`define PPA_RUNNING_OFF 8'h10
`define PPA_COUNT_OFF 8'h14
`define PPA_FLAGS_OFF 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PPA_CTRL_PRIO_LSB 0
`define PPA_CTRL_TB_BIT 4
`define PPA_CTRL_MODE_LSB 8
`define PPA_CTRL_IRQEN_BIT 12
`define PPA_CTRL_SVC_BIT 16
`define PPA_FLAG_INT_BIT 0
`define PPA_FLAG_DMA_BIT 1
`define PPA_FLAG_OVR_BIT 2
`define PPA_FLAG_VALID_BIT 3
`define PPA_STAT_LSB 24

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define PPA_OVF_FLAG 8'h80
`define PPA_BAD_MODE 8'h01
`define PPA_BAD_TB 8'h02
`define PPA_TARGET_MAX 24'h07FFFF
`define PPA_RST_WORD 32'h0000_0000
`define PPA_RESP_OKAY 2'h0
`define PPA_RESP_SLVERR 2'h2

`endif

// ==== shared/ppa_pkg.sv ====
// types for the period and pulse accumulator channel
// assumes ppa_defines.svh is compiled alongside
package ppa_pkg;

    typedef enum logic [1:0] {MODE_HIGH, MODE_LOW, MODE_RISE, MODE_FALL}
        meas_mode_t;

    typedef enum logic [1:0] {FN_OFF, FN_ARMED, FN_ACTIVE} fn_state_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
        logic rise;
        logic fall;
    } pin_sync_t;

    typedef struct packed {
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [1:0] prio;
        logic tb_sel;
        meas_mode_t mode;
        logic irq_en;
        logic [23:0] target;
        logic [23:0] interval;
        fn_state_t fn;
        logic [23:0] cur;
        logic [23:0] acc;
        logic [7:0] acc_ovf;
        logic [23:0] count;
        logic [23:0] result;
        logic [7:0] status;
        logic valid;
        logic int_flag;
        logic dma_flag;
        logic overrun;
        logic irq;
    } ppa_state_t;

endpackage

// ==== test/period_pulse_accumulator_bench.sv ====
// self-checking bench for period_pulse_accumulator
// assumes ppa_pin_model as pin source; ticks come from a divider here
`timescale 1ns/1ps
`default_nettype none
`include "ppa_defines.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
$display("unexpected at %0t got %h exp %h", $time, g, e); end end
module period_pulse_accumulator_bench;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic tick1 = 1'b0, tick2 = 1'b0, step = 1'b0, run = 1'b0, ack = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic pin, awready, wready, bvalid, arready, rvalid, dma_req, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [1:0] bresp, rresp, last_resp;
    logic [3:0] hi = 4'h2, lo = 4'h2;
    logic [2:0] cyc = 3'h0;
    int n_errors = 0, total_checks = 0, seed = 32'hF5290521;

    always #5 ref_clk_i = ~ref_clk_i;
    // pin edges land two cycles off every tick, so counts are exact
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 3'h1;
        tick1 <= (cyc[1:0] == 2'h3);
        tick2 <= (cyc == 3'h7);
        step <= (cyc[1:0] == 2'h1);
    end

    ppa_pin_model i_ppa_pin_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .run_i(run), .step_i(step), .high_units_i(hi), .low_units_i(lo),
        .pin_o(pin));
    period_pulse_accumulator i_period_pulse_accumulator (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .meas_pin_i(pin),
        .timebase_first_tick_i(tick1), .timebase_second_tick_i(tick2),
        .dma_ack_i(ack), .dma_req_o(dma_req), .irq_o(irq),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

    task automatic close_out(input int late);
        n_errors += late;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one register access; w selects write, a read leaves its word in rv
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i;
        @(posedge ref_clk_i);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awv <= w;
        wv <= w;
        arv <= !w;
        bready <= w;
        rready <= !w;
        for (i = 0; i < 50; i++)
        begin
            @(posedge ref_clk_i);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
            if (arready) arv <= 1'b0;
            if (w ? bvalid : rvalid) break;
        end
        if (i == 50) close_out(1);
        rv = rdata;
        last_resp = w ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
    endtask

    task automatic setup(input int m, tb, ie, t, iv);
        logic [31:0] c;
        c = 32'(m) << `PPA_CTRL_MODE_LSB | 32'(tb) << `PPA_CTRL_TB_BIT |
            32'(ie) << `PPA_CTRL_IRQEN_BIT;
        xfer(1'b1, `PPA_CTRL_OFF, 32'h0);
        xfer(1'b1, `PPA_TARGET_OFF, 32'(t));
        xfer(1'b1, `PPA_INTERVAL_OFF, 32'(iv));
        xfer(1'b1, `PPA_CTRL_OFF, c);
        xfer(1'b1, `PPA_CTRL_OFF, c | 32'h1 << `PPA_CTRL_SVC_BIT);
        xfer(1'b1, `PPA_CTRL_OFF, c | 32'h1);
        xfer(1'b1, `PPA_FLAGS_OFF, 32'h7);
    endtask

    // widths in steps; one step is one tick of the first timebase
    function automatic logic [23:0] expect_total(int m, h, l, t, tb);
        int w;
        w = (m == 0) ? h : (m == 1) ? l : h + l;
        return 24'(((t == 0) ? 1 : t) * w >> tb);
    endfunction

    initial
    begin
        int i, k, ie;
        logic [23:0] e;
        repeat (6) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (k = 0; k <= 24; k += 4)
        begin
            xfer(1'b0, 8'(k), 32'h0);
            `CHK(rv, 32'h0)
        end
        xfer(1'b0, 8'h1C, 32'h0);
        `CHK({last_resp, rv}, {`PPA_RESP_SLVERR, 32'h0})
        xfer(1'b1, 8'h1C, 32'hFFFFFFFF);
        `CHK(last_resp, `PPA_RESP_SLVERR)
        xfer(1'b1, `PPA_TARGET_OFF, 32'hFFFFFFFF);
        xfer(1'b0, `PPA_TARGET_OFF, 32'h0);
        `CHK(rv, {8'h00, `PPA_TARGET_MAX})
        $display("test registers done");
        for (k = 0; k < 4; k++)
        begin
            hi <= 4'(2 + 2 * ($unsigned($random(seed)) % 3));
            lo <= 4'(2 + 2 * ($unsigned($random(seed)) % 3));
            ie = (k < 2);
            setup(k, k % 2, ie, k, 0);
            run <= 1'b1;
            for (i = 0; i < 300; i++)
            begin
                xfer(1'b0, `PPA_FLAGS_OFF, 32'h0);
                if (rv[`PPA_FLAG_INT_BIT]) break;
            end
            if (i == 300) close_out(1);
            e = expect_total(k, hi, lo, k, k % 2);
            `CHK(irq, 1'(ie))
            `CHK(dma_req, 1'b1)
            xfer(1'b0, `PPA_RESULT_OFF, 32'h0);
            `CHK(rv, {8'h00, e})
            ack <= 1'b1;
            @(posedge ref_clk_i);
            ack <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
            for (i = 0; i < 600 && dma_req !== 1'b1; i++)
                @(posedge ref_clk_i);
            if (i == 600) close_out(1);
            xfer(1'b0, `PPA_RESULT_OFF, 32'h0);
            `CHK(rv, {8'h00, e})
            run <= 1'b0;
            xfer(1'b0, `PPA_FLAGS_OFF, 32'h0);
            `CHK(rv[3:0], 4'hF)
            xfer(1'b1, `PPA_FLAGS_OFF, 32'h7);
            xfer(1'b0, `PPA_FLAGS_OFF, 32'h0);
            `CHK(rv[3:0], 4'h8)
            $display("test mode %0d done", k);
        end
        hi <= 4'hE;
        lo <= 4'h2;
        setup(0, 0, 0, 3, 2);
        run <= 1'b1;
        for (i = 0; i < 99 && pin !== 1'b0; i++)
            @(posedge ref_clk_i);
        if (i == 99) close_out(1);
        for (i = 0; i < 99 && pin !== 1'b1; i++)
            @(posedge ref_clk_i);
        if (i == 99) close_out(1);
        repeat (30) @(posedge ref_clk_i);
        xfer(1'b0, `PPA_RUNNING_OFF, 32'h0);
        `CHK(rv[31:24], 8'h00)
        `CHK(rv[23:0] != 24'h0, 1'b1)
        xfer(1'b0, `PPA_COUNT_OFF, 32'h0);
        `CHK(rv, 32'h0)
        xfer(1'b1, `PPA_CTRL_OFF, 32'h1 << `PPA_CTRL_MODE_LSB | 32'h1);
        xfer(1'b0, `PPA_RUNNING_OFF, 32'h0);
        `CHK(rv[31:24], `PPA_BAD_MODE)
        xfer(1'b1, `PPA_CTRL_OFF, 32'h1 << `PPA_CTRL_MODE_LSB | 32'h1 |
            32'h1 << `PPA_CTRL_TB_BIT);
        xfer(1'b0, `PPA_RUNNING_OFF, 32'h0);
        `CHK(rv[31:24], `PPA_BAD_MODE | `PPA_BAD_TB)
        run <= 1'b0;
        $display("test interim done");
        close_out(0);
    end
endmodule
`default_nettype wire

// ==== test/period_pulse_accumulator_sva.sv ====
// checker for the register port and request outputs of the accumulator
// assumes it is bound to period_pulse_accumulator and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module period_pulse_accumulator_sva (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // requests
    input wire logic dma_ack_i,
    input wire logic dma_req_o,
    input wire logic irq_o,
    // register port
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    wresp_hold_a: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response withdrawn early");
    rdata_hold_a: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data changed before rready");
    read_block_a: assert property (
        s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address accepted during a read");
    write_block_a: assert property (
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write accepted during a response");
    read_answer_a: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read not answered next cycle");
    write_answer_a: assert property (
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
        s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
        else $error("write not answered in two cycles");
    dma_hold_a: assert property (
        dma_req_o && !dma_ack_i |=> dma_req_o || $rose(s_axi_bvalid_o))
        else $error("dma request dropped without cause");
    irq_hold_a: assert property (
        irq_o |=> irq_o || $rose(s_axi_bvalid_o))
        else $error("interrupt dropped without a write");
endmodule

bind period_pulse_accumulator period_pulse_accumulator_sva i_sva (
    .ref_clk_i, .resetn_i, .dma_ack_i, .dma_req_o, .irq_o,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i);
`default_nettype wire

// ==== test/ppa_pin_model.sv ====
// model of the measured signal source: square wave of whole-step widths
// assumes step_i pulses once per first-timebase tick period
`timescale 1ns/1ps
`default_nettype none
module ppa_pin_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // control
    input wire logic run_i,
    input wire logic step_i,
    input wire logic [3:0] high_units_i,
    input wire logic [3:0] low_units_i,
    // pin
    output logic pin_o
);
    logic [3:0] left_q;
    // edges only on steps, so they never land on a tick; a stopped
    // source holds its level as a real driver would
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_o <= 1'b0;
            left_q <= 4'h0;
        end
        else if (!run_i)
            left_q <= 4'h0;
        else if (step_i && left_q <= 4'h1)
        begin
            pin_o <= !pin_o;
            left_q <= pin_o ? low_units_i : high_units_i;
        end
        else if (step_i)
            left_q <= left_q - 4'h1;
    end
endmodule
`default_nettype wire
